// File: bench/test_viterbi_traceback_rounding.sv
// Self-checking bench for the traceback and rounding datapath.
`timescale 1ns/100ps
module test_viterbi_traceback_rounding;
  import vtr_pkg::*;
  logic i_ref_clk = 0;
  logic i_reset_n = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] o_wb_dat;
  logic [31:0] o_add_result;
  logic o_wb_ack;
  vtr_instr_t instr;
  vtr_mem_wr_t mem_wr;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] t_low = 32'hA5C3_0F96;
  logic [31:0] t_high = 32'h3C69_E1D2;
  logic [5:0] st;
  logic b;
  logic [31:0] av[7] = '{32'h0000_000B, 32'h0000_000B, ZERO_WORD, ZERO_WORD, ZERO_WORD,
                         ZERO_WORD, 32'h0000_0005};
  logic [31:0] bv[7] = '{32'h0000_000D, 32'h0000_000D, 32'hFFFF_FFFA, 32'hFFFF_FFFA,
                         32'hFFFF_FFFE, 32'hFFFF_FFFD, 32'h0000_0007};
  logic [4:0] sv[7] = '{5'h03, 5'h03, 5'h02, 5'h02, 5'h02, 5'h02, 5'h00};
  logic rv[7] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
  logic [31:0] ev[7] = '{32'h0000_000C, 32'h0000_000D, 32'hFFFF_FFFE, 32'hFFFF_FFFF,
                         ZERO_WORD, 32'hFFFF_FFFF, 32'h0000_000C};

  always #50 i_ref_clk = ~i_ref_clk;

  vtr_core dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_instr(instr), .o_mem_wr(mem_wr),
    .o_add_result(o_add_result));
  vtr_host_model host_u (.i_ref_clk(i_ref_clk), .i_mem_wr(mem_wr), .o_instr(instr));

  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, lanes};
    do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, ZERO_WORD);
    chk(rdat, exp);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(3000 * 100);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rd(ADDR_STATUS, ZERO_WORD);
    rd(8'h20, ZERO_WORD);
    wb(1'b1, ADDR_TRANS_LOW, ZERO_WORD);
    wb(1'b1, ADDR_TRANS_HIGH, ZERO_WORD);
    host_u.issue(OP_SEL_LOW, '0, 32'h0001_0005, 32'h0005_0001, '0);
    host_u.issue(OP_SEL_HIGH, '0, 32'h0005_0001, 32'h0005_0001, '0);
    rd(ADDR_TRANS_LOW, 32'h0000_0001);
    rd(ADDR_TRANS_HIGH, 32'h0000_0003);
    host_u.issue(OP_CLEAR_TRANS, '0, '0, '0, '0);
    rd(ADDR_TRANS_LOW, ZERO_WORD);
    rd(ADDR_TRANS_HIGH, ZERO_WORD);
    lanes = 4'h2;
    wb(1'b1, ADDR_TRANS_LOW, 32'hFFFF_FFFF);
    lanes = 4'hF;
    rd(ADDR_TRANS_LOW, 32'h0000_FF00);
    $display("test select and clear done");
    wb(1'b1, ADDR_STATUS, 32'h0000_0001);
    wb(1'b1, ADDR_TRANS_LOW, t_low);
    wb(1'b1, ADDR_TRANS_HIGH, t_high);
    wb(1'b1, ADDR_STATE, ZERO_WORD);
    st = 6'h00;
    for (int i = 0; i < 10; i++) begin
      b = st < STATE_SPLIT ? t_low[LOW_TOP - st] : t_high[HIGH_TOP - st];
      host_u.issue(OP_TRACE_MEM, 32'h0000_0100 + i, '0, '0, '0);
      chk(host_u.last_wr.data, {31'h0, b});
      chk({host_u.last_wr.valid, host_u.last_wr.addr[30:0]}, 32'h8000_0100 + i);
      st = {st[4:0], b};
    end
    rd(ADDR_STATE, {26'h0, st});
    wb(1'b1, ADDR_STATE, 32'hFFFF_FFE5);
    st = 6'h25;
    b = t_high[HIGH_TOP - st];
    host_u.issue(OP_TRACE_REG, '0, '0, '0, '0);
    wb(1'b1, ADDR_RESULT, 32'hFFFF_FFFF);
    rd(ADDR_RESULT, {31'h0, b});
    rd(ADDR_STATE, {26'h0, st[4:0], b});
    rd(ADDR_STATUS, 32'h0000_0001);
    $display("test traceback done");
    foreach (av[k]) begin
      wb(1'b1, ADDR_STATUS, {31'h0, rv[k]});
      host_u.issue(OP_ADD_SHR, '0, av[k], bv[k], sv[k]);
      chk(o_add_result, ev[k]);
    end
    $display("test rounding done");
    finish_test();
  end
endmodule

// File: bench/vtr_host_model.sv
// Host pipeline model that issues instructions and captures memory writes.
`timescale 1ns/100ps
module vtr_host_model
  import vtr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire vtr_mem_wr_t i_mem_wr,
  output vtr_instr_t o_instr
);
  vtr_mem_wr_t last_wr;
  initial o_instr = '0;
  // Issues one single-cycle instruction, then samples the memory write port.
  task automatic issue(input logic [15:0] op, input logic [31:0] ptr, a, b,
                       input logic [4:0] sh);
    vtr_instr_t ins;
    ins = {1'b1, op, ptr, a, b, sh};
    @(posedge i_ref_clk);
    o_instr <= ins;
    @(posedge i_ref_clk);
    // Released fields are inverted so that no stale operand looks valid.
    ins = ~ins;
    ins.valid = 1'b0;
    o_instr <= ins;
    #1 last_wr = i_mem_wr;
  endtask
endmodule

// File: include/vtr_pkg.sv
// Package with the constants and types of the traceback and rounding datapath.
package vtr_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned SUM_W = DATA_W + FRAC_W;
  localparam int unsigned STATE_W = 6;

  // Instruction opcodes as seen in the low word.
  localparam logic [15:0] OP_CLEAR_TRANS = 16'hE529;
  localparam logic [15:0] OP_TRACE_MEM = 16'hE20C;
  localparam logic [15:0] OP_TRACE_REG = 16'hE528;
  localparam logic [15:0] OP_SEL_LOW = 16'hE6F6;
  localparam logic [15:0] OP_SEL_HIGH = 16'hE6F7;
  localparam logic [15:0] OP_ADD_SHR = 16'hE5F0;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADDR_TRANS_LOW = 8'h00;
  localparam logic [7:0] ADDR_TRANS_HIGH = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int unsigned STATUS_RND_BIT = 0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [STATE_W-1:0] STATE_SPLIT = 6'h20;
  localparam logic [STATE_W-1:0] LOW_TOP = 6'h1F;
  localparam logic [STATE_W-1:0] HIGH_TOP = 6'h3F;
  localparam logic [SUM_W-1:0] HALF_LSB = 48'h0000_0000_8000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [DATA_W-1:0] mem_ptr;
    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic [4:0] shift;
  } vtr_instr_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } vtr_mem_wr_t;
endpackage

// File: logic/vtr_core.sv
// Traceback, transition register and rounding datapath with a Wishbone slave.
//
// What this block does
// - Clear instruction zeroes both transition bit registers.
// - Traceback takes state from bits 5:0 and zeroes bits 31:6.
// - States 0..31 use low register bit 31-s, others high bit 63-s.
// - New state index is twice old index plus selected bit, six bits.
// - Memory traceback writes word with selected bit at 0, zeros above.
// - Register traceback puts selected bit in result bit 0, zeros above.
// - Clear and both traceback forms finish in one cycle.
// - None of these instructions touches the status register.
// - With rounding enabled, half an LSB is added before truncation.
// - With rounding disabled, the shifted result is simply truncated.
// - Fraction bits survive addition and rounding, removed only at the end.
// - Select instructions shift both transition registers left, new bits at 0.
`timescale 1ns/100ps
module vtr_core
  import vtr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire vtr_instr_t i_instr,
  output vtr_mem_wr_t o_mem_wr,
  output logic [31:0] o_add_result
);
  logic [31:0] trans_low_reg, trans_low_next;
  logic [31:0] trans_high_reg, trans_high_next;
  logic [31:0] state_reg, state_next;
  logic [31:0] result_reg, result_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] add_result_reg, add_result_next;
  vtr_mem_wr_t mem_wr_reg, mem_wr_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  logic bus_req;
  logic bus_wr;
  logic [31:0] byte_mask;
  logic [STATE_W-1:0] cur_state;
  logic [4:0] trans_idx;
  logic sel_bit;
  logic is_trace;
  logic sel0_bit;
  logic sel1_bit;
  logic signed [SUM_W-1:0] wide_a;
  logic signed [SUM_W-1:0] wide_b;
  logic [SUM_W-1:0] sum_plain;
  logic [SUM_W-1:0] sum_round;

  assign bus_req = i_wb_cyc && i_wb_stb && !ack_reg;
  assign bus_wr = bus_req && i_wb_we;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign byte_mask[8*g +: 8] = {8{i_wb_sel[g]}};
    end
  endgenerate

  // Traceback selection from the current state index.
  always_comb begin
    cur_state = state_reg[STATE_W-1:0];
    if (cur_state < STATE_SPLIT) begin
      trans_idx = 5'(LOW_TOP - cur_state);
      sel_bit = trans_low_reg[trans_idx];
    end else begin
      trans_idx = 5'(HIGH_TOP - cur_state);
      sel_bit = trans_high_reg[trans_idx];
    end
  end

  assign is_trace = i_instr.valid &&
    (i_instr.opcode == OP_TRACE_MEM || i_instr.opcode == OP_TRACE_REG);

  // Metric compares: a transition bit is zero when the low metric wins.
  assign sel0_bit = !($signed(i_instr.opa[15:0]) > $signed(i_instr.opa[31:16]));
  assign sel1_bit = !($signed(i_instr.opb[15:0]) > $signed(i_instr.opb[31:16]));

  // Add with right shift; fraction kept in the low FRAC_W bits until the end.
  always_comb begin
    wide_a = $signed({i_instr.opa, FRAC_ZERO});
    wide_b = $signed({i_instr.opb, FRAC_ZERO}) >>> i_instr.shift;
    sum_plain = SUM_W'(wide_a + wide_b);
    sum_round = sum_plain + HALF_LSB;
  end

  // Next values of the register state.
  always_comb begin
    trans_low_next = trans_low_reg;
    trans_high_next = trans_high_reg;
    state_next = state_reg;
    result_next = result_reg;
    status_next = status_reg;
    add_result_next = add_result_reg;
    mem_wr_next = '0;
    ack_next = bus_req;
    rdata_next = ZERO_WORD;

    if (bus_req && !i_wb_we) begin
      if (i_wb_adr == ADDR_TRANS_LOW) begin
        rdata_next = trans_low_reg;
      end else if (i_wb_adr == ADDR_TRANS_HIGH) begin
        rdata_next = trans_high_reg;
      end else if (i_wb_adr == ADDR_STATE) begin
        rdata_next = state_reg;
      end else if (i_wb_adr == ADDR_RESULT) begin
        rdata_next = result_reg;
      end else if (i_wb_adr == ADDR_STATUS) begin
        rdata_next = status_reg;
      end else begin
        rdata_next = ZERO_WORD;
      end
    end

    if (bus_wr) begin
      if (i_wb_adr == ADDR_TRANS_LOW) begin
        trans_low_next = (trans_low_reg & ~byte_mask) | (i_wb_dat & byte_mask);
      end else if (i_wb_adr == ADDR_TRANS_HIGH) begin
        trans_high_next = (trans_high_reg & ~byte_mask) | (i_wb_dat & byte_mask);
      end else if (i_wb_adr == ADDR_STATE) begin
        state_next = (state_reg & ~byte_mask) | (i_wb_dat & byte_mask);
      end else if (i_wb_adr == ADDR_STATUS) begin
        status_next = (status_reg & ~byte_mask) | (i_wb_dat & byte_mask);
      end
    end

    // An instruction issued in the same cycle as a bus write wins.
    if (i_instr.valid) begin
      case (i_instr.opcode)
        OP_CLEAR_TRANS: begin
          trans_low_next = ZERO_WORD;
          trans_high_next = ZERO_WORD;
        end
        OP_TRACE_MEM: begin
          // The cast zero-fills the upper bits, so no stale state bit survives a step.
          state_next = DATA_W'({cur_state[STATE_W-2:0], sel_bit});
          mem_wr_next.valid = 1'b1;
          mem_wr_next.addr = i_instr.mem_ptr;
          mem_wr_next.data = DATA_W'(sel_bit);
        end
        OP_TRACE_REG: begin
          state_next = DATA_W'({cur_state[STATE_W-2:0], sel_bit});
          result_next = DATA_W'(sel_bit);
        end
        OP_SEL_LOW, OP_SEL_HIGH: begin
          trans_low_next = {trans_low_reg[DATA_W-2:0], sel0_bit};
          trans_high_next = {trans_high_reg[DATA_W-2:0], sel1_bit};
        end
        OP_ADD_SHR: begin
          if (status_reg[STATUS_RND_BIT]) begin
            add_result_next = sum_round[SUM_W-1:FRAC_W];
          end else begin
            add_result_next = sum_plain[SUM_W-1:FRAC_W];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      trans_low_reg <= ZERO_WORD;
      trans_high_reg <= ZERO_WORD;
      state_reg <= ZERO_WORD;
      result_reg <= ZERO_WORD;
      status_reg <= ZERO_WORD;
      add_result_reg <= ZERO_WORD;
      mem_wr_reg <= '0;
      ack_reg <= 1'b0;
      rdata_reg <= ZERO_WORD;
    end else begin
      trans_low_reg <= trans_low_next;
      trans_high_reg <= trans_high_next;
      state_reg <= state_next;
      result_reg <= result_next;
      status_reg <= status_next;
      add_result_reg <= add_result_next;
      mem_wr_reg <= mem_wr_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdata_reg;
  assign o_mem_wr = mem_wr_reg;
  assign o_add_result = add_result_reg;

  // Checks of the datapath against its intended behaviour.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  logic [31:0] trunc_sum;
  logic half_bit;
  assign trunc_sum = sum_plain[SUM_W-1:FRAC_W];
  assign half_bit = sum_plain[FRAC_W-1];

  a_clear_zeroes_both: assert property (
    i_instr.valid && i_instr.opcode == OP_CLEAR_TRANS
      |=> trans_low_reg == ZERO_WORD && trans_high_reg == ZERO_WORD)
    else $error("Transition registers not cleared.");

  a_trace_state_upper: assert property (
    is_trace |=> state_reg[31:6] == 26'h000_0000)
    else $error("State upper bits not zeroed by traceback.");

  a_trace_bit_pick: assert property (
    i_instr.valid && i_instr.opcode == OP_TRACE_REG
      |=> result_reg[0] == ($past(state_reg[5]) ? $past(trans_high_reg[~state_reg[4:0]])
                                                 : $past(trans_low_reg[~state_reg[4:0]])))
    else $error("Wrong transition bit selected.");

  a_state_doubles: assert property (
    is_trace |=> state_reg[5:0] == {$past(state_reg[4:0]), $past(sel_bit)})
    else $error("State index not doubled plus bit.");

  a_mem_word_once: assert property (
    i_instr.valid && i_instr.opcode == OP_TRACE_MEM
      |=> o_mem_wr.valid && o_mem_wr.data == {31'h0000_0000, $past(sel_bit)}
          && o_mem_wr.addr == $past(i_instr.mem_ptr) ##1 !o_mem_wr.valid || $past(is_trace))
    else $error("Memory traceback word wrong or late.");

  a_reg_result_form: assert property (
    i_instr.valid && i_instr.opcode == OP_TRACE_REG
      |=> result_reg[31:1] == 31'h0000_0000 && result_reg[0] == $past(sel_bit))
    else $error("Register traceback result wrong.");

  a_status_kept: assert property (
    i_instr.valid && !bus_wr |=> $stable(status_reg))
    else $error("Instruction changed the status register.");

  a_round_on_half: assert property (
    i_instr.valid && i_instr.opcode == OP_ADD_SHR && status_reg[STATUS_RND_BIT]
      |=> o_add_result == $past(trunc_sum) + {31'h0000_0000, $past(half_bit)})
    else $error("Rounded result wrong.");

  a_round_off_trunc: assert property (
    i_instr.valid && i_instr.opcode == OP_ADD_SHR && !status_reg[STATUS_RND_BIT]
      |=> o_add_result == $past(trunc_sum))
    else $error("Truncated result wrong.");

  a_select_shift_in: assert property (
    i_instr.valid && i_instr.opcode == OP_SEL_LOW
      |=> trans_low_reg == {$past(trans_low_reg[30:0]), $past(sel0_bit)}
          && trans_high_reg == {$past(trans_high_reg[30:0]), $past(sel1_bit)})
    else $error("Select did not shift transition bits.");

  a_ack_single_cycle: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Ack held longer than one cycle.");

  // The checks below work from ports, opcodes and registers; only the last two also use the datapath's own terms bus_wr and is_trace.
  a_ack_follows_req: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("Bus request not acknowledged in the next cycle.");

  a_select_high_shift: assert property (
    i_instr.valid && i_instr.opcode == OP_SEL_HIGH
      |=> trans_low_reg[0] == $past($signed(i_instr.opa[15:0]) <= $signed(i_instr.opa[31:16]))
          && trans_low_reg[DATA_W-1:1] == $past(trans_low_reg[DATA_W-2:0]))
    else $error("High select did not shift the low-state register.");

  a_mem_only_on_trace: assert property (
    o_mem_wr.valid |-> $past(i_instr.valid) && $past(i_instr.opcode) == OP_TRACE_MEM)
    else $error("Memory write without a memory traceback.");

  a_result_read_only: assert property (
    !(i_instr.valid && i_instr.opcode == OP_TRACE_REG) |=> $stable(result_reg))
    else $error("Result register changed without a register traceback.");

  a_result_upper_zero: assert property (
    result_reg[DATA_W-1:1] == '0)
    else $error("Result register holds upper bits.");

  a_add_result_holds: assert property (
    !(i_instr.valid && i_instr.opcode == OP_ADD_SHR) |=> $stable(o_add_result))
    else $error("Add result changed without an add instruction.");

  a_add_unshifted: assert property (
    i_instr.valid && i_instr.opcode == OP_ADD_SHR && i_instr.shift == 5'h00
      |=> o_add_result == $past(i_instr.opa + i_instr.opb))
    else $error("Unshifted add result wrong.");

  a_clear_keeps_state: assert property (
    i_instr.valid && i_instr.opcode == OP_CLEAR_TRANS && !bus_wr
      |=> $stable(state_reg) && $stable(result_reg))
    else $error("Clear changed the traceback registers.");

  a_trace_keeps_bits: assert property (
    is_trace && !bus_wr |=> $stable(trans_low_reg) && $stable(trans_high_reg))
    else $error("Traceback changed the transition registers.");
endmodule
